// File: verilog/mmvd_pkg.sv
`default_nettype none
package mmvd_pkg;

  // ==========================================================================
  // register port map (8-bit registers, 4-bit index)
  localparam logic [3:0] REG_MEM_EXP   = 4'h0;
  localparam logic [3:0] REG_CPU_CTRL  = 4'h1;
  localparam logic [3:0] REG_STATUS    = 4'h2;

  // mem_expansion_reg fields
  localparam int         MEX_EXT_EN_BIT = 0;
  localparam int         MEX_RAM_SEL_BIT = 3;
  localparam int         MEX_ROM_LO_BIT = 5;
  localparam int         MEX_ROM_HI_BIT = 6;
  localparam logic [7:0] MEM_EXP_RST   = 8'h00;
  localparam logic [7:0] MEM_EXP_WMASK = 8'h69;

  // cpu_control_word fields
  localparam int         CTRL_RELOC_BIT = 1;
  localparam logic [7:0] CPU_CTRL_RST  = 8'h00;
  localparam logic [7:0] CPU_CTRL_WMASK = 8'h02;

  // ==========================================================================
  // address map
  localparam int          ADDR_W         = 16;
  localparam logic [15:0] ROM_END_48K    = 16'hC000;
  localparam logic [15:0] ROM_END_32K    = 16'h8000;
  localparam logic [15:0] ROM_END_24K    = 16'h6000;
  localparam logic [15:0] ROM_END_16K    = 16'h4000;
  localparam logic [15:0] RAM_BASE_2K    = 16'hF700;
  localparam logic [15:0] RAM_BASE_1K    = 16'hFB00;
  localparam logic [15:0] RAM_BASE_768   = 16'hFC00;
  localparam logic [7:0]  MAIN_RAM_PAGE  = 8'hFE;
  localparam logic [7:0]  SFR_PAGE       = 8'hFF;
  localparam logic [15:0] VEC_TABLE_END  = 16'h0040;
  localparam logic [15:0] VEC_RELOC_BASE = 16'h8000;

  // vector entry indices (entry address = index * 2)
  localparam int          VEC_IDX_W      = 5;
  localparam logic [4:0]  VEC_IDX_RESET  = 5'h00;
  localparam logic [4:0]  VEC_IDX_NMI    = 5'h01;
  localparam logic [4:0]  VEC_IDX_WDT    = 5'h02;
  localparam logic [4:0]  VEC_IDX_OPTRAP = 5'h1E;
  localparam logic [4:0]  VEC_IDX_BREAK  = 5'h1F;

  typedef enum logic [1:0] {RGN_ROM, RGN_RAM, RGN_EXT, RGN_SFR} mmvd_region_e;

endpackage
`default_nettype wire

// File: verilog/mmvd_region_dec.sv
`timescale 1ns/1ps
`default_nettype none
module mmvd_region_dec #(
  parameter bit JOINT_SIZE = 1'b0
) (
  input  wire logic [15:0]         addr_i,         // cpu address
  input  wire logic                rom_present_i,  // rom mapped in this mode
  input  wire logic [1:0]          rom_sel_i,      // size select hi,lo
  input  wire logic                ram_sel_i,      // ram size select
  output var mmvd_pkg::mmvd_region_e region_o,     // decoded region
  output logic                     vec_area_o,     // inside vector table
  output logic                     main_ram_o      // inside main ram page
);

  logic [15:0] rom_end;
  logic [15:0] ram_base;

  // ==========================================================================
  // size selection
  always_comb begin
    if (JOINT_SIZE) begin
      case (rom_sel_i)
        2'b00:   begin rom_end = mmvd_pkg::ROM_END_48K; ram_base = mmvd_pkg::RAM_BASE_2K; end
        2'b01:   begin rom_end = mmvd_pkg::ROM_END_32K; ram_base = mmvd_pkg::RAM_BASE_2K; end
        2'b10:   begin rom_end = mmvd_pkg::ROM_END_32K; ram_base = mmvd_pkg::RAM_BASE_1K; end
        default: begin rom_end = mmvd_pkg::ROM_END_24K; ram_base = mmvd_pkg::RAM_BASE_768; end
      endcase
    end else begin
      case (rom_sel_i)
        2'b00:   rom_end = mmvd_pkg::ROM_END_48K;
        2'b01:   rom_end = mmvd_pkg::ROM_END_32K;
        2'b10:   rom_end = mmvd_pkg::ROM_END_24K;
        default: rom_end = mmvd_pkg::ROM_END_16K;
      endcase
      ram_base = ram_sel_i ? mmvd_pkg::RAM_BASE_1K : mmvd_pkg::RAM_BASE_2K;
    end
  end

  // ==========================================================================
  // region decode, sfr page first
  always_comb begin
    if (addr_i[15:8] == mmvd_pkg::SFR_PAGE) begin
      region_o = mmvd_pkg::RGN_SFR;
    end else if (addr_i >= ram_base) begin
      region_o = mmvd_pkg::RGN_RAM;
    end else if (rom_present_i && (addr_i < rom_end)) begin
      region_o = mmvd_pkg::RGN_ROM;
    end else begin
      region_o = mmvd_pkg::RGN_EXT;
    end
  end

  assign vec_area_o = addr_i < mmvd_pkg::VEC_TABLE_END;
  assign main_ram_o = addr_i[15:8] == mmvd_pkg::MAIN_RAM_PAGE;

endmodule
`default_nettype wire

// File: verilog/mmvd_vec_fetch.sv
`timescale 1ns/1ps
`default_nettype none
module mmvd_vec_fetch (
  input  wire logic        clk_i,       // system clock
  input  wire logic        rst_n_i,     // sync reset, active low
  input  wire logic        req_i,       // vector request pulse
  input  wire logic [4:0]  idx_i,       // vector entry index
  input  wire logic        reloc_i,     // relocate table high
  output logic             busy_o,      // fetch in progress
  output logic             rd_o,        // byte read strobe
  output logic [15:0]      rd_addr_o,   // byte read address
  input  wire logic [7:0]  rd_data_i,   // byte read data, next cycle
  output logic             pc_load_o,   // program counter load pulse
  output logic [15:0]      pc_o         // new program counter
);

  typedef enum logic [1:0] {ST_IDLE, ST_LO, ST_HI, ST_WAIT} mmvd_vec_state_e;

  mmvd_vec_state_e state_q;
  logic [15:0]     entry_q;
  logic [7:0]      lo_q;
  logic [15:0]     entry_d;

  // ==========================================================================
  // entry address; reset entry never relocates
  always_comb begin
    entry_d = {10'h000, idx_i, 1'b0};
    if (reloc_i && (idx_i != mmvd_pkg::VEC_IDX_RESET)) begin
      entry_d = entry_d | mmvd_pkg::VEC_RELOC_BASE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: if (req_i) state_q <= ST_LO;
        ST_LO:   state_q <= ST_HI;
        ST_HI:   state_q <= ST_WAIT;
        ST_WAIT: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      entry_q <= 16'h0000;
    end else if (state_q == ST_IDLE && req_i) begin
      entry_q <= entry_d;
    end
  end

  // even byte to pc low, odd byte to pc high
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      lo_q      <= 8'h00;
      pc_o      <= 16'h0000;
      pc_load_o <= 1'b0;
    end else begin
      pc_load_o <= state_q == ST_WAIT;
      if (state_q == ST_HI) begin
        lo_q <= rd_data_i;
      end
      if (state_q == ST_WAIT) begin
        pc_o <= {rd_data_i, lo_q};
      end
    end
  end

  assign busy_o    = state_q != ST_IDLE;
  assign rd_o      = (state_q == ST_LO) || (state_q == ST_HI);
  assign rd_addr_o = {entry_q[15:1], state_q == ST_HI};

endmodule
`default_nettype wire

// File: verilog/mmvd_top.sv
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module mmvd_top #(
  parameter bit JOINT_SIZE    = 1'b0,  // joint rom/ram size decode
  parameter bit HAS_ROMLESS   = 1'b1,  // romless modes exist
  parameter bit HAS_CTRL_WORD = 1'b1   // control word exists
) (
  input  wire logic        CLK_I,           // system clock
  input  wire logic        RST_N_I,         // sync reset, active low
  input  wire logic [3:0]  REG_ADDR_I,      // register index
  input  wire logic [7:0]  REG_WDATA_I,     // register write data
  input  wire logic        REG_WR_I,        // register write strobe
  input  wire logic        REG_RD_I,        // register read strobe
  output logic [7:0]       REG_RDATA_O,     // register read data
  input  wire logic        BOOT_CFG_PIN0_I, // mode strap 0
  input  wire logic        BOOT_CFG_PIN1_I, // mode strap 1
  input  wire logic        CPU_REQ_I,       // cpu access strobe
  input  wire logic [15:0] CPU_ADDR_I,      // cpu reference address
  input  wire logic        CPU_WORD_I,      // word access
  output logic             ACC_VALID_O,     // decode result pulse
  output logic [1:0]       REGION_O,        // decoded region
  output logic             VEC_AREA_O,      // vector table hit
  output logic             ACC_FAULT_O,     // external without expansion
  output logic [15:0]      LO_ADDR_O,       // low byte address
  output logic [15:0]      HI_ADDR_O,       // high byte address
  input  wire logic        VEC_REQ_I,       // interrupt accepted pulse
  input  wire logic [4:0]  VEC_IDX_I,       // vector entry index
  output logic             VEC_BUSY_O,      // vector fetch busy
  output logic             VMEM_RD_O,       // vector byte read
  output logic [15:0]      VMEM_ADDR_O,     // vector byte address
  input  wire logic [7:0]  VMEM_DATA_I,     // vector byte data
  output logic             PC_LOAD_O,       // pc load pulse
  output logic [15:0]      PC_O             // pc value
);

  logic [7:0]              mem_expansion_reg_q;
  logic [7:0]              cpu_control_word_q;
  logic                    strap_done_q;
  logic [1:0]              boot_mode_q;
  logic                    rom_present;
  logic                    vector_table_relocate;
  mmvd_pkg::mmvd_region_e  region;
  logic                    vec_area;
  logic                    main_ram;
  logic [7:0]              rdata_d;

  assign rom_present           = !(HAS_ROMLESS && boot_mode_q[0]);
  assign vector_table_relocate = HAS_CTRL_WORD && cpu_control_word_q[mmvd_pkg::CTRL_RELOC_BIT];

  // ==========================================================================
  // mode straps caught once after reset release
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      strap_done_q <= 1'b0;
      boot_mode_q  <= 2'b00;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      boot_mode_q  <= {BOOT_CFG_PIN1_I, BOOT_CFG_PIN0_I};
    end
  end

  // ==========================================================================
  // register port
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      mem_expansion_reg_q <= mmvd_pkg::MEM_EXP_RST;
    end else if (REG_WR_I && REG_ADDR_I == mmvd_pkg::REG_MEM_EXP) begin
      mem_expansion_reg_q <= REG_WDATA_I & mmvd_pkg::MEM_EXP_WMASK;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      cpu_control_word_q <= mmvd_pkg::CPU_CTRL_RST;
    end else if (HAS_CTRL_WORD && REG_WR_I && REG_ADDR_I == mmvd_pkg::REG_CPU_CTRL) begin
      cpu_control_word_q <= REG_WDATA_I & mmvd_pkg::CPU_CTRL_WMASK;
    end
  end

  always_comb begin
    case (REG_ADDR_I)
      mmvd_pkg::REG_MEM_EXP:  rdata_d = mem_expansion_reg_q;
      mmvd_pkg::REG_CPU_CTRL: rdata_d = cpu_control_word_q;
      mmvd_pkg::REG_STATUS:   rdata_d = {4'h0, rom_present, VEC_BUSY_O, boot_mode_q};
      default:                rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      REG_RDATA_O <= 8'h00;
    end else if (REG_RD_I) begin
      REG_RDATA_O <= rdata_d;
    end else begin
      REG_RDATA_O <= 8'h00;
    end
  end

  // ==========================================================================
  // address decode
  mmvd_region_dec #(
    .JOINT_SIZE (JOINT_SIZE)
  ) u_dec (
    .addr_i        (CPU_ADDR_I),
    .rom_present_i (rom_present),
    .rom_sel_i     ({mem_expansion_reg_q[mmvd_pkg::MEX_ROM_HI_BIT],
                     mem_expansion_reg_q[mmvd_pkg::MEX_ROM_LO_BIT]}),
    .ram_sel_i     (mem_expansion_reg_q[mmvd_pkg::MEX_RAM_SEL_BIT]),
    .region_o      (region),
    .vec_area_o    (vec_area),
    .main_ram_o    (main_ram)
  );

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      ACC_VALID_O <= 1'b0;
      REGION_O    <= 2'b00;
      VEC_AREA_O  <= 1'b0;
      ACC_FAULT_O <= 1'b0;
    end else begin
      ACC_VALID_O <= CPU_REQ_I;
      if (CPU_REQ_I) begin
        REGION_O    <= region;
        VEC_AREA_O  <= vec_area;
        ACC_FAULT_O <= (region == mmvd_pkg::RGN_EXT)
                       && !mem_expansion_reg_q[mmvd_pkg::MEX_EXT_EN_BIT];
      end
    end
  end

  // byte pairing for word accesses; byte access drives both lanes, addr and addr+1, like an even word
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      LO_ADDR_O <= 16'h0000;
      HI_ADDR_O <= 16'h0000;
    end else if (CPU_REQ_I) begin
      if (CPU_WORD_I && main_ram && CPU_ADDR_I[0]) begin
        LO_ADDR_O <= CPU_ADDR_I - 16'h0001;
        HI_ADDR_O <= CPU_ADDR_I;
      end else begin
        LO_ADDR_O <= CPU_ADDR_I;
        HI_ADDR_O <= CPU_ADDR_I + 16'h0001;
      end
    end
  end

  // ==========================================================================
  // vector fetch
  mmvd_vec_fetch u_vec (
    .clk_i     (CLK_I),
    .rst_n_i   (RST_N_I),
    .req_i     (VEC_REQ_I),
    .idx_i     (VEC_IDX_I),
    .reloc_i   (vector_table_relocate),
    .busy_o    (VEC_BUSY_O),
    .rd_o      (VMEM_RD_O),
    .rd_addr_o (VMEM_ADDR_O),
    .rd_data_i (VMEM_DATA_I),
    .pc_load_o (PC_LOAD_O),
    .pc_o      (PC_O)
  );

  // ==========================================================================
  // checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  logic vec_accept;
  assign vec_accept = VEC_REQ_I && !VEC_BUSY_O;

  a_sfr_page_route: assert property (
    CPU_REQ_I && CPU_ADDR_I[15:8] == 8'hFF |=> REGION_O == mmvd_pkg::RGN_SFR)
    else $error("sfr page not routed to sfr");

  a_rom_low_hit: assert property (
    CPU_REQ_I && rom_present && CPU_ADDR_I < 16'h4000 |=> REGION_O == mmvd_pkg::RGN_ROM)
    else $error("low address in rom mode not rom");

  a_romless_ext: assert property (
    CPU_REQ_I && !rom_present && CPU_ADDR_I < 16'hF700 |=> REGION_O == mmvd_pkg::RGN_EXT)
    else $error("romless low address not external");

  a_rom_size_48k: assert property (
    CPU_REQ_I && rom_present && mem_expansion_reg_q[6:5] == 2'b00 && CPU_ADDR_I == 16'hBFFF
    |=> REGION_O == mmvd_pkg::RGN_ROM)
    else $error("48K rom top byte not rom");

  a_rom_size_edge: assert property (
    CPU_REQ_I && !JOINT_SIZE && mem_expansion_reg_q[6:5] == 2'b11 && CPU_ADDR_I == 16'h4000
    |=> REGION_O == mmvd_pkg::RGN_EXT)
    else $error("address above 16K rom not external");

  a_ram_small_free: assert property (
    CPU_REQ_I && !JOINT_SIZE && mem_expansion_reg_q[3] && CPU_ADDR_I == 16'hFAFF
    |=> REGION_O != mmvd_pkg::RGN_RAM)
    else $error("freed ram address still ram");

  a_ram_joint_768: assert property (
    CPU_REQ_I && JOINT_SIZE && mem_expansion_reg_q[6:5] == 2'b11 && CPU_ADDR_I == 16'hFBFF
    |=> REGION_O != mmvd_pkg::RGN_RAM)
    else $error("joint 768 ram too large");

  a_word_odd_main: assert property (
    CPU_REQ_I && CPU_WORD_I && CPU_ADDR_I[15:8] == 8'hFE && CPU_ADDR_I[0]
    |=> LO_ADDR_O == HI_ADDR_O - 16'h0001 && HI_ADDR_O == $past(CPU_ADDR_I))
    else $error("odd main ram word pairs wrong bytes");

  a_word_periph: assert property (
    CPU_REQ_I && CPU_ADDR_I[15:8] == 8'hFD
    |=> LO_ADDR_O == $past(CPU_ADDR_I) && HI_ADDR_O == LO_ADDR_O + 16'h0001)
    else $error("peripheral ram word pairs wrong bytes");

  a_vec_area_mark: assert property (
    CPU_REQ_I && CPU_ADDR_I < 16'h0040 |=> VEC_AREA_O)
    else $error("vector table not marked");

  a_vec_sequence: assert property (
    vec_accept |=> (VMEM_RD_O && !VMEM_ADDR_O[0]) ##1 (VMEM_RD_O && VMEM_ADDR_O[0])
    ##1 !VMEM_RD_O ##1 PC_LOAD_O)
    else $error("vector fetch sequence broken");

  a_pc_byte_order: assert property (
    PC_LOAD_O |-> PC_O == {$past(VMEM_DATA_I, 1), $past(VMEM_DATA_I, 2)})
    else $error("pc bytes swapped");

  a_vec_reset_fixed: assert property (
    vec_accept && VEC_IDX_I == 5'h00 |=> VMEM_ADDR_O == 16'h0000)
    else $error("reset vector not at zero");

  a_vec_relocated: assert property (
    vec_accept && VEC_IDX_I != 5'h00 && vector_table_relocate
    |=> VMEM_ADDR_O == {10'h200, $past(VEC_IDX_I), 1'b0})
    else $error("relocated vector address wrong");

  a_vec_low_table: assert property (
    vec_accept && VEC_IDX_I == 5'h02 && !vector_table_relocate |=> VMEM_ADDR_O == 16'h0004)
    else $error("watchdog vector address wrong");

  // ==========================================================================
  // access result checks
  a_acc_valid_pulse: assert property (
    CPU_REQ_I |=> ACC_VALID_O)
    else $error("decode result pulse missing");

  a_ext_fault_flag: assert property (
    CPU_REQ_I && CPU_ADDR_I >= 16'hC000 && CPU_ADDR_I <= 16'hF6FF && !mem_expansion_reg_q[0]
    |=> ACC_FAULT_O)
    else $error("external access without expansion not flagged");

  a_ram_2k_base: assert property (
    CPU_REQ_I && !JOINT_SIZE && !mem_expansion_reg_q[3] && CPU_ADDR_I == 16'hF700
    |=> REGION_O == mmvd_pkg::RGN_RAM)
    else $error("2K ram base not ram");

  // ==========================================================================
  // vector entry and pc checks
  a_vec_nmi_entry: assert property (
    vec_accept && VEC_IDX_I == 5'h01 && !vector_table_relocate |=> VMEM_ADDR_O == 16'h0002)
    else $error("nmi vector address wrong");

  a_vec_wdt_reloc: assert property (
    vec_accept && VEC_IDX_I == 5'h02 && vector_table_relocate |=> VMEM_ADDR_O == 16'h8004)
    else $error("relocated watchdog vector address wrong");

  a_vec_trap_entry: assert property (
    vec_accept && VEC_IDX_I == 5'h1E && !vector_table_relocate |=> VMEM_ADDR_O == 16'h003C)
    else $error("trap vector address wrong");

  a_vec_break_entry: assert property (
    vec_accept && VEC_IDX_I == 5'h1F && !vector_table_relocate |=> VMEM_ADDR_O == 16'h003E)
    else $error("break vector address wrong");

  a_vec_busy_span: assert property (
    vec_accept |=> VEC_BUSY_O [*3] ##1 !VEC_BUSY_O)
    else $error("vector fetch busy span wrong");

  a_pc_hold: assert property (
    !PC_LOAD_O |-> $stable(PC_O))
    else $error("pc changed without load");

  c_reloc_fetch: cover property (vec_accept && vector_table_relocate ##4 PC_LOAD_O);
  c_romless_ext: cover property (CPU_REQ_I && !rom_present ##1 REGION_O == mmvd_pkg::RGN_EXT);
  c_odd_main_word: cover property (CPU_REQ_I && CPU_WORD_I && main_ram && CPU_ADDR_I[0]);
  c_joint_small_ram: cover property (CPU_REQ_I && JOINT_SIZE && mem_expansion_reg_q[6:5] == 2'b11);
  c_busy_refused: cover property (VEC_REQ_I && VEC_BUSY_O);

endmodule
`default_nettype wire

// File: verif/mmvd_vmem_model.sv
`timescale 1ns/1ps
`default_nettype none
module mmvd_vmem_model (
  input  wire logic        clk_i,   // system clock
  input  wire logic        rd_i,    // byte read strobe
  input  wire logic [15:0] addr_i,  // byte read address
  output var  logic [7:0]  data_o   // byte data, cycle after read
);
  // ====================
  // vector memory contents: fixed pattern of the address
  always @(posedge clk_i) begin
    if (rd_i) begin
      data_o <= addr_i[7:0] ^ addr_i[15:8] ^ 8'h5A;
    end else begin
      data_o <= ~(addr_i[7:0] ^ addr_i[15:8] ^ 8'h5A); // stale data never looks valid
    end
  end
endmodule
`default_nettype wire

// File: verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [1:0] RROM = mmvd_pkg::RGN_ROM;
  localparam logic [1:0] RRAM = mmvd_pkg::RGN_RAM;
  localparam logic [1:0] REXT = mmvd_pkg::RGN_EXT;
  localparam logic [1:0] RSFR = mmvd_pkg::RGN_SFR;
  logic        clk, rst_n, rwr, rrd, p0, p1, creq, cword, vreq, ext_en;
  logic        valid, vec_area, fault, vbusy, vrd, pcld;
  logic [3:0]  radr;
  logic [4:0]  vidx;
  logic [1:0]  region, region_j;
  logic [7:0]  rwd, rdat, vdat;
  logic [15:0] cadr, lo, hi, vadr, pc;
  int          error_cnt, n_checks, cyc;
  logic [15:0] rom_end [4] = '{16'hC000, 16'h8000, 16'h6000, 16'h4000};
  logic [15:0] jrom [4] = '{16'hC000, 16'h8000, 16'h8000, 16'h6000};
  logic [15:0] jram [4] = '{16'hF700, 16'hF700, 16'hFB00, 16'hFC00};
  logic [15:0] map_a [12] = '{16'h0000, 16'h003F, 16'h0040, 16'hBFFF, 16'hC000, 16'hF6FF,
                              16'hF700, 16'hFDFF, 16'hFE00, 16'hFEFF, 16'hFF00, 16'hFFFF};
  logic [1:0]  map_r [12] = '{RROM, RROM, RROM, RROM, REXT, REXT,
                              RRAM, RRAM, RRAM, RRAM, RSFR, RSFR};
  logic [4:0]  vec_ix [5] = '{5'h00, 5'h01, 5'h02, 5'h1E, 5'h1F};

  mmvd_top dut_u (
    .CLK_I(clk), .RST_N_I(rst_n), .REG_ADDR_I(radr), .REG_WDATA_I(rwd), .REG_WR_I(rwr),
    .REG_RD_I(rrd), .REG_RDATA_O(rdat), .BOOT_CFG_PIN0_I(p0), .BOOT_CFG_PIN1_I(p1),
    .CPU_REQ_I(creq), .CPU_ADDR_I(cadr), .CPU_WORD_I(cword), .ACC_VALID_O(valid),
    .REGION_O(region), .VEC_AREA_O(vec_area), .ACC_FAULT_O(fault), .LO_ADDR_O(lo),
    .HI_ADDR_O(hi), .VEC_REQ_I(vreq), .VEC_IDX_I(vidx), .VEC_BUSY_O(vbusy),
    .VMEM_RD_O(vrd), .VMEM_ADDR_O(vadr), .VMEM_DATA_I(vdat), .PC_LOAD_O(pcld), .PC_O(pc)
  );
  mmvd_vmem_model vmem_u (.clk_i(clk), .rd_i(vrd), .addr_i(vadr), .data_o(vdat));
  // joint size decode, no romless mode
  mmvd_top #(.JOINT_SIZE(1'b1), .HAS_ROMLESS(1'b0)) dut_j_u (
    .CLK_I(clk), .RST_N_I(rst_n), .REG_ADDR_I(radr), .REG_WDATA_I(rwd), .REG_WR_I(rwr),
    .REG_RD_I(rrd), .REG_RDATA_O(), .BOOT_CFG_PIN0_I(p0), .BOOT_CFG_PIN1_I(p1),
    .CPU_REQ_I(creq), .CPU_ADDR_I(cadr), .CPU_WORD_I(cword), .ACC_VALID_O(),
    .REGION_O(region_j), .VEC_AREA_O(), .ACC_FAULT_O(), .LO_ADDR_O(),
    .HI_ADDR_O(), .VEC_REQ_I(vreq), .VEC_IDX_I(vidx), .VEC_BUSY_O(),
    .VMEM_RD_O(), .VMEM_ADDR_O(), .VMEM_DATA_I(vdat), .PC_LOAD_O(), .PC_O()
  );

  always #2 clk = ~clk;

  // ====================
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      final_report();
    end
  end

  // ====================
  // compare and report
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk16(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  function automatic logic [7:0] mem(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction

  // ====================
  // access tasks
  task automatic do_reset();
    rst_n <= 1'b0;
    ext_en = 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    radr <= a;
    rwd  <= d;
    rwr  <= 1'b1;
    @(posedge clk);
    rwr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    radr <= a;
    rrd  <= 1'b1;
    @(posedge clk);
    rrd <= 1'b0;
    #1;
    chk8(rdat, e);
  endtask
  task automatic cpu(input logic [15:0] a, input logic w, input logic [1:0] rg);
    logic odd_main;
    odd_main = w && a[0] && (a[15:8] == mmvd_pkg::MAIN_RAM_PAGE);
    @(posedge clk);
    cadr  <= a;
    cword <= w;
    creq  <= 1'b1;
    @(posedge clk);
    creq <= 1'b0;
    #1;
    chk8({7'h00, valid}, 8'h01);
    chk8({6'h00, region}, {6'h00, rg});
    chk8({7'h00, vec_area}, {7'h00, a < mmvd_pkg::VEC_TABLE_END});
    chk8({7'h00, fault}, {7'h00, rg == REXT && !ext_en});
    chk16(lo, odd_main ? a - 16'h0001 : a);
    chk16(hi, odd_main ? a : a + 16'h0001);
  endtask
  task automatic cpu_j(input logic [15:0] a, input logic [1:0] rg);
    @(posedge clk);
    cadr <= a;
    creq <= 1'b1;
    @(posedge clk);
    creq <= 1'b0;
    #1;
    chk8({6'h00, region_j}, {6'h00, rg});
  endtask
  task automatic vec(input logic [4:0] ix, input logic rl);
    logic [15:0] ent;
    ent = {10'h000, ix, 1'b0};
    if (rl && ix != mmvd_pkg::VEC_IDX_RESET) begin
      ent = ent | mmvd_pkg::VEC_RELOC_BASE;
    end
    @(posedge clk);
    vidx <= ix;
    vreq <= 1'b1;
    @(posedge clk);
    vidx <= ix ^ 5'h01; // second request while busy, ignored
    #1;
    chk8({6'h00, vbusy, vrd}, 8'h03);
    chk16(vadr, ent);
    @(posedge clk);
    vreq <= 1'b0;
    #1;
    chk16(vadr, ent + 16'h0001);
    repeat (2) @(posedge clk);
    #1;
    chk8({6'h00, vbusy, pcld}, 8'h01);
    chk16(pc, {mem(ent + 16'h0001), mem(ent)});
  endtask

  // ====================
  // test sequence
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    {rwr, rrd, p0, p1, creq, cword, vreq} = '0;
    radr = 4'h0;
    rwd = 8'h00;
    cadr = 16'h0000;
    vidx = 5'h00;
    error_cnt = 0;
    n_checks = 0;
    do_reset();
    rd_chk(mmvd_pkg::REG_MEM_EXP, 8'h00);
    rd_chk(mmvd_pkg::REG_CPU_CTRL, 8'h00);
    rd_chk(mmvd_pkg::REG_STATUS, 8'h08);
    wr(4'hF, 8'hFF);
    rd_chk(4'hF, 8'h00);
    wr(mmvd_pkg::REG_MEM_EXP, 8'hFF);
    rd_chk(mmvd_pkg::REG_MEM_EXP, mmvd_pkg::MEM_EXP_WMASK);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      wr(mmvd_pkg::REG_MEM_EXP, {1'b0, 2'(i), 5'h01});
      ext_en = 1'b1;
      cpu(rom_end[i] - 16'h0001, 1'b0, RROM);
      cpu(rom_end[i], 1'b0, REXT);
      cpu_j(jrom[i] - 16'h0001, RROM);
      cpu_j(jrom[i], REXT);
      cpu_j(jram[i] - 16'h0001, REXT);
      cpu_j(jram[i], RRAM);
    end
    wr(mmvd_pkg::REG_MEM_EXP, 8'h01);
    for (int i = 0; i < 12; i++) begin
      cpu(map_a[i], 1'b0, map_r[i]);
    end
    $display("test rom map done");
    wr(mmvd_pkg::REG_MEM_EXP, 8'h09);
    cpu(16'hF700, 1'b0, REXT);
    cpu(16'hFAFF, 1'b0, REXT);
    cpu(16'hFB00, 1'b0, RRAM);
    wr(mmvd_pkg::REG_MEM_EXP, 8'h00);
    ext_en = 1'b0;
    cpu(16'hC000, 1'b0, REXT);
    cpu(16'h0100, 1'b0, RROM);
    $display("test ram size done");
    cpu(16'hFE21, 1'b1, RRAM);
    cpu(16'hFE20, 1'b1, RRAM);
    cpu(16'hFEFF, 1'b1, RRAM);
    cpu(16'hFD01, 1'b1, RRAM);
    cpu(16'hFE21, 1'b0, RRAM);
    $display("test word pairing done");
    for (int r = 0; r < 2; r++) begin
      wr(mmvd_pkg::REG_CPU_CTRL, {6'h00, 1'(r), 1'b0});
      for (int k = 0; k < 5; k++) begin
        vec(vec_ix[k], 1'(r));
      end
    end
    $display("test vectors done");
    for (int s = 0; s < 2; s++) begin
      @(posedge clk);
      p0 <= 1'b1;
      p1 <= 1'(s);
      do_reset();
      rd_chk(mmvd_pkg::REG_STATUS, {6'h00, 1'(s), 1'b1});
      wr(mmvd_pkg::REG_MEM_EXP, 8'h01);
      ext_en = 1'b1;
      cpu(16'h0000, 1'b0, REXT);
      cpu(16'hF6FF, 1'b0, REXT);
      cpu(16'hF700, 1'b0, RRAM);
      cpu_j(16'h0000, RROM);
    end
    $display("test romless done");
    final_report();
  end
endmodule
`default_nettype wire
